// ### rtl/sstf_sector_status.sv
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
`include "sstf_consts.svh"
module sstf_sector_status (
  input wire logic core_clk, // 100 MHz
  input wire logic rst, // Sync, active high
  input wire sstf_pkg::sstf_regbus_t bus, // Register request
  output logic [7:0] regRdData, // Read data, next cycle
  input wire sstf_pkg::sstf_cmd_t decoderCommandField, // Decoder command
  input wire logic repeatCorrection, // Repeat correction active
  input wire sstf_pkg::sstf_result_t result, // Sector result
  input wire logic [23:0] targetAddr, // Target min/sec/block
  input wire logic [7:0] blockStatusByte, // Sub CPU block status
  input wire logic [7:0] byteStatusValue, // Sub CPU byte status
  input wire logic [7:0] subchannelStatus, // Sub CPU subcode status
  input wire logic dataStrobe, // One data byte from DSP
  input wire logic erasurePointer, // Its erasure flag
  input wire logic subStrobe, // One subcode byte
  input wire logic [7:0] subByte, // Subcode P..W
  output logic flagWrEn, // Byte flag write
  output logic [7:0] flagWrData, // Byte flag data
  output logic subWrEn, // Subcode write
  output logic [7:0] subWrData, // Subcode data
  output logic sectorBufInhibit, // Sector data blocked
  input wire logic [19:0] limitAddr, // Address under check
  output logic limitReached, // Address hit limit
  output logic [8:0] lastOrderArea, // Last order area
  input wire logic xferStart, // Sector ready to send
  input wire logic [19:0] xferBase, // Sector base address
  output logic bufRdEn, // Buffer read
  output logic [19:0] bufRdAddr, // Buffer address
  input wire logic [7:0] bufRdData, // Data, next cycle
  output logic [7:0] hostData, // Byte to host
  output logic hostValid, // Byte valid
  input wire logic hostReady, // Host takes byte
  output logic hostBlockEnd, // Last byte of split block
  output logic hostSectorEnd, // Sector finished
  output logic xferBusy // Transfer running
);
  import sstf_pkg::*;

  logic [8:0] lim;
  logic [7:0] fmt0;
  logic [7:0] fmt1;
  logic [3:0] stsA;
  logic [2:0] stsB;
  logic [7:0] info;
  logic [19:0] base;
  logic [11:0] cnt;
  sstf_seg_t seg;
  sstf_xstate_t state;
  logic [2:0] flagCnt;
  logic [6:0] flagShift;
  logic [7:0] blkOr;
  logic [7:0] blkLatched;
  logic [2:0] qCnt;
  logic [6:0] qShift;
  logic iMode;
  logic iForm;
  logic split;
  logic flagActive;
  logic subActive;
  logic [7:0] flagByte;
  logic [11:0] splitMask;

  function automatic logic buffersFlags(input sstf_cmd_t c);
    buffersFlags = (c == CMD_WRONLY) || (c == CMD_RT) || (c == CMD_AUDIO);
  endfunction : buffersFlags

  function automatic logic segOn(input sstf_seg_t s);
    case (s)
      SG_SYNC: segOn = fmt0[`SSTF_F0_SYNC] && !split;
      SG_HDR: segOn = fmt0[`SSTF_F0_HDR] && !split;
      SG_SUB: segOn = fmt0[`SSTF_F0_SUB] && iMode && !split;
      SG_USER: segOn = fmt0[`SSTF_F0_USER] || split;
      SG_PAR: segOn = fmt0[`SSTF_F0_PAR] && !split;
      SG_FLAGS: segOn = fmt1[`SSTF_F1_BYTEN] && fmt0[`SSTF_F0_USER] && !split;
      SG_BLK: segOn = fmt1[`SSTF_F1_BLKEN] && !split;
      SG_SUBC: segOn = fmt1[`SSTF_F1_SBCEN] && !split;
      SG_STAT: segOn = fmt1[`SSTF_F1_SBCEN] && fmt1[`SSTF_F1_SBCSTS] && !split;
      SG_PAD: segOn = fmt1[`SSTF_F1_SBCEN] && fmt1[`SSTF_F1_SBCSTS]
                      && !fmt1[`SSTF_F1_ALL_SUBCHANNEL_SELECT] && fmt1[`SSTF_F1_ZPAD] && !split;
      default: segOn = 1'b0;
    endcase
  endfunction : segOn

  function automatic logic [11:0] segLen(input sstf_seg_t s);
    case (s)
      SG_SYNC: segLen = `SSTF_LEN_SYNC;
      SG_HDR: segLen = `SSTF_LEN_HDR;
      SG_SUB: segLen = `SSTF_LEN_SUB;
      SG_USER: segLen = iForm ? `SSTF_LEN_USER2 : `SSTF_LEN_USER1;
      SG_PAR: segLen = !iMode ? `SSTF_LEN_PAR1 : (iForm ? `SSTF_LEN_PAR22 : `SSTF_LEN_PAR21);
      SG_FLAGS: segLen = `SSTF_LEN_FLAGS;
      SG_SUBC: segLen = fmt1[`SSTF_F1_ALL_SUBCHANNEL_SELECT] ? `SSTF_LEN_SUBALL : `SSTF_LEN_SUBQ;
      SG_PAD: segLen = `SSTF_LEN_PAD;
      default: segLen = 12'd1;
    endcase
  endfunction : segLen

  // Mode 2 layout keeps subheader, data and parity contiguous, so
  // all three selects give 2336 bytes whatever the form bit says
  function automatic logic [11:0] segOfs(input sstf_seg_t s);
    case (s)
      SG_HDR: segOfs = `SSTF_OFS_HDR;
      SG_SUB: segOfs = `SSTF_OFS_SUB;
      SG_USER: segOfs = iMode ? `SSTF_OFS_DATA2 : `SSTF_OFS_SUB;
      SG_PAR: segOfs = !iMode ? `SSTF_OFS_PAR1 : (iForm ? `SSTF_OFS_PAR22 : `SSTF_OFS_PAR21);
      SG_FLAGS: segOfs = `SSTF_OFS_FLAGS;
      SG_SUBC: segOfs = `SSTF_OFS_SUBC;
      default: segOfs = 12'd0;
    endcase
  endfunction : segOfs

  assign iMode = info[`SSTF_INFO_MODE];
  assign iForm = info[`SSTF_INFO_FORM] && iMode;
  assign split = fmt0[`SSTF_F0_K1] || fmt0[`SSTF_F0_K05];
  assign splitMask = fmt0[`SSTF_F0_K1] ? `SSTF_MASK_1K : `SSTF_MASK_512;
  // Sector data and subcode cannot share the buffer
  assign sectorBufInhibit = fmt1[`SSTF_F1_SBCEN];
  assign flagActive = fmt1[`SSTF_F1_BYTEN] && fmt0[`SSTF_F0_USER]
                      && buffersFlags(decoderCommandField) && !sectorBufInhibit;
  assign subActive = fmt1[`SSTF_F1_SBCEN] && (decoderCommandField == CMD_AUDIO);
  assign flagByte = fmt1[`SSTF_F1_BYTSL] ? byteStatusValue : {flagShift, erasurePointer};
  assign xferBusy = (state != XS_IDLE);
  assign bufRdEn = (state == XS_INFO)
                   || ((state == XS_FETCH) && (seg != SG_BLK) && (seg != SG_STAT) && (seg != SG_PAD));
  assign bufRdAddr = base + {8'h00, (state == XS_INFO) ? `SSTF_OFS_INFO : 12'(segOfs(seg) + cnt)};
  assign hostBlockEnd = (state == XS_SEND) && hostReady && (seg == SG_USER) && split
                        && ((cnt & splitMask) == splitMask);

  // Register writes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lastOrderArea <= 9'h000;
      lim <= 9'h000;
      fmt0 <= `SSTF_RST_BYTE;
      fmt1 <= `SSTF_RST_BYTE;
    end else if (bus.wr) begin
      case (bus.addr)
        `SSTF_A_LOA_H: lastOrderArea[8] <= bus.wdata[0];
        `SSTF_A_LOA_L: lastOrderArea[7:0] <= bus.wdata;
        `SSTF_A_LIM_H: lim[8] <= bus.wdata[0];
        `SSTF_A_LIM_L: lim[7:0] <= bus.wdata;
        `SSTF_A_FMT0: fmt0 <= bus.wdata;
        `SSTF_A_FMT1: fmt1 <= bus.wdata;
        default: ;
      endcase
    end
  end

  // Read data lives one cycle only
  always_ff @(posedge core_clk) begin
    if (rst || !bus.rd) begin
      regRdData <= 8'h00;
    end else begin
      case (bus.addr)
        `SSTF_A_STS_A: regRdData <= {4'h0, stsA};
        `SSTF_A_STS_B: regRdData <= {5'h00, stsB};
        `SSTF_A_LOA_H: regRdData <= {7'h00, lastOrderArea[8]};
        `SSTF_A_LOA_L: regRdData <= lastOrderArea[7:0];
        `SSTF_A_LIM_H: regRdData <= {7'h00, lim[8]};
        `SSTF_A_LIM_L: regRdData <= lim[7:0];
        `SSTF_A_FMT0: regRdData <= fmt0;
        `SSTF_A_FMT1: regRdData <= fmt1;
        default: regRdData <= 8'h00;
      endcase
    end
  end

  // Per-sector decode results
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stsA <= 4'h0;
      stsB <= 3'h0;
    end else if (result.done) begin
      stsA[3] <= result.corrected;
      stsA[2] <= result.edcErr;
      stsA[1] <= result.eccErr;
      stsA[0] <= (result.curAddr != targetAddr);
      stsB[2] <= (result.edcParityFlag == 4'h0) && (result.edcParity == 32'h0000_0000);
      if ((decoderCommandField == CMD_RT) || repeatCorrection) begin
        stsB[1] <= result.mode;
        stsB[0] <= result.form && result.mode;
      end
    end
  end

  // Limit check, low 11 bits implied ones
  always_ff @(posedge core_clk) begin
    if (rst) begin
      limitReached <= 1'b0;
    end else begin
      limitReached <= (!fmt0[`SSTF_F0_AUTO] || (decoderCommandField == CMD_SUBC))
                      && (limitAddr == {lim, `SSTF_LIM_LOW});
    end
  end

  // Byte flag buffering, eight data bytes per flag byte
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flagCnt <= 3'd0;
      flagShift <= 7'h00;
      flagWrEn <= 1'b0;
      flagWrData <= 8'h00;
    end else begin
      flagWrEn <= 1'b0;
      if (result.done) begin
        flagCnt <= 3'd0;
      end else if (dataStrobe && flagActive) begin
        flagShift <= {flagShift[5:0], erasurePointer};
        flagCnt <= flagCnt + 3'd1;
        if (flagCnt == 3'd7) begin
          flagWrEn <= 1'b1;
          flagWrData <= flagByte;
        end
      end
    end
  end

  // OR of flags for block flag; a byte landing with done joins the old sector
  always_ff @(posedge core_clk) begin
    if (rst) begin
      blkOr <= 8'h00;
      blkLatched <= 8'h00;
    end else if (result.done) begin
      blkLatched <= {7'h00, |(blkOr | (flagWrEn ? flagWrData : 8'h00))};
      blkOr <= 8'h00;
    end else if (flagWrEn) begin
      blkOr <= blkOr | flagWrData;
    end
  end

  // Subcode buffering
  always_ff @(posedge core_clk) begin
    if (rst) begin
      qCnt <= 3'd0;
      qShift <= 7'h00;
      subWrEn <= 1'b0;
      subWrData <= 8'h00;
    end else begin
      subWrEn <= 1'b0;
      if (subStrobe && subActive) begin
        if (fmt1[`SSTF_F1_ALL_SUBCHANNEL_SELECT]) begin
          subWrEn <= 1'b1;
          subWrData <= subByte;
        end else begin
          qShift <= {qShift[5:0], subByte[`SSTF_Q_BIT]};
          qCnt <= qCnt + 3'd1;
          if (qCnt == 3'd7) begin
            subWrEn <= 1'b1;
            subWrData <= {qShift, subByte[`SSTF_Q_BIT]};
          end
        end
      end
    end
  end

  // Automatic transfer sequencer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= XS_IDLE;
      seg <= SG_SYNC;
      cnt <= 12'd0;
      info <= 8'h00;
      base <= 20'h00000;
      hostData <= 8'h00;
      hostValid <= 1'b0;
      hostSectorEnd <= 1'b0;
    end else begin
      hostSectorEnd <= 1'b0;
      case (state)
        XS_IDLE: begin
          if (xferStart && fmt0[`SSTF_F0_AUTO]) begin
            base <= xferBase;
            state <= XS_INFO;
          end
        end
        XS_INFO: state <= XS_PLAN;
        XS_PLAN: begin
          info <= bufRdData;
          seg <= SG_SYNC;
          state <= XS_SEL;
        end
        XS_SEL: begin
          cnt <= 12'd0;
          if (seg == SG_END) begin
            hostSectorEnd <= 1'b1;
            state <= XS_IDLE;
          end else if (segOn(seg)) begin
            state <= XS_FETCH;
          end else begin
            seg <= sstf_seg_t'(seg + 4'h1);
          end
        end
        XS_FETCH: state <= XS_CAPT;
        XS_CAPT: begin
          hostValid <= 1'b1;
          case (seg)
            SG_BLK: hostData <= fmt1[`SSTF_F1_BLKSL] ? blockStatusByte : blkLatched;
            SG_STAT: hostData <= subchannelStatus;
            SG_PAD: hostData <= 8'h00;
            default: hostData <= bufRdData;
          endcase
          state <= XS_SEND;
        end
        XS_SEND: begin
          if (hostReady) begin
            hostValid <= 1'b0;
            if (cnt == 12'(segLen(seg) - 12'd1)) begin
              seg <= sstf_seg_t'(seg + 4'h1);
              state <= XS_SEL;
            end else begin
              cnt <= cnt + 12'd1;
              state <= XS_FETCH;
            end
          end
        end
        default: state <= XS_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_corr_flag: assert property (result.done |=> stsA[3] == $past(result.corrected))
    else $error("correction flag wrong");
  a_edc_flag: assert property (result.done |=> stsA[2] == $past(result.edcErr))
    else $error("edc flag wrong");
  a_ecc_flag: assert property (result.done |=> stsA[1] == $past(result.eccErr))
    else $error("ecc flag wrong");
  a_tgt_compare: assert property (result.done |=> stsA[0] == ($past(result.curAddr) != $past(targetAddr)))
    else $error("target compare wrong");
  a_edc_zero: assert property (result.done && (result.edcParityFlag != 4'h0) |=> !stsB[2])
    else $error("edc zero with flags");
  a_mode_hold: assert property (result.done && !repeatCorrection && (decoderCommandField != CMD_RT)
    |=> $stable(stsB[1:0]))
    else $error("mode changed outside correction");
  a_loa_low: assert property (bus.wr && (bus.addr == `SSTF_A_LOA_L) |=> lastOrderArea[7:0] == $past(bus.wdata))
    else $error("last area not stored");
  a_lim_match: assert property (limitReached |-> $past(limitAddr) == {$past(lim), `SSTF_LIM_LOW})
    else $error("limit mismatch");
  a_info_fetch: assert property (xferStart && fmt0[`SSTF_F0_AUTO] && (state == XS_IDLE)
    |=> bufRdEn && (bufRdAddr == xferBase + {8'h00, `SSTF_OFS_INFO}) ##2 state == XS_SEL)
    else $error("info word not read");
  a_sync_gate: assert property (hostValid && (seg == SG_SYNC) |-> fmt0[`SSTF_F0_SYNC])
    else $error("sync sent unselected");
  a_sub_mode: assert property (hostValid && (seg == SG_SUB) |-> iMode)
    else $error("subheader in mode 1");
  a_split_user: assert property (hostBlockEnd |-> (seg == SG_USER) && hostValid)
    else $error("split end outside data");
  a_pad_zero: assert property (hostValid && (seg == SG_PAD) |-> hostData == 8'h00)
    else $error("pad byte not zero");
  a_flag_src: assert property (dataStrobe && flagActive && fmt1[`SSTF_F1_BYTSL] && !result.done
    && (flagCnt == 3'd7) |=> flagWrEn && (flagWrData == $past(byteStatusValue)))
    else $error("flag source wrong");
  // Checked at capture, since the host may stall a byte for many cycles
  a_blk_source: assert property ((state == XS_CAPT) && (seg == SG_BLK) && fmt1[`SSTF_F1_BLKSL]
    |=> hostData == $past(blockStatusByte))
    else $error("block flag source wrong");
  a_stat_byte: assert property ((state == XS_CAPT) && (seg == SG_STAT)
    |=> hostData == $past(subchannelStatus))
    else $error("subcode status byte wrong");
  a_sub_audio: assert property (subWrEn
    |-> ($past(decoderCommandField) == CMD_AUDIO) && $past(fmt1[`SSTF_F1_SBCEN]))
    else $error("subcode written outside audio");
  a_flag_gate: assert property (flagWrEn
    |-> $past(fmt1[`SSTF_F1_BYTEN]) && $past(fmt0[`SSTF_F0_USER]))
    else $error("flag written while disabled");

  c_sector_end: cover property (hostSectorEnd);
  c_split_end: cover property (hostBlockEnd);
  c_flag_write: cover property (flagWrEn);
  c_sub_write: cover property (subWrEn);
  c_block_byte: cover property (hostValid && (seg == SG_BLK));
endmodule : sstf_sector_status

// ### rtl/sstf_consts.svh
`ifndef SSTF_CONSTS_SVH
`define SSTF_CONSTS_SVH
// Contract
// - Flag corrected bytes in current sector
// - Flag EDC check failure
// - Flag uncorrectable error header through parity
// - Flag address versus target mismatch
// - Flag EDC parity bytes clean and zero
// - Report discriminated mode and form
// - Hold nine-bit last order area
// - Limit is nine bits plus 7FFh
// - Read sector info word before sending
// - Split user data into 1024/512 blocks
// - Sync and header sent only when selected
// - Subheader sent only for mode 2
// - User data 2048 or 2324 bytes
// - Parity 288, 280 or 4 bytes
// - Block flag from status or OR
// - Buffer byte flags in flagged commands
// - Byte flags from status or erasure
// - Buffer all subcode or Q only
// - Subcode status byte, optional five zeros
// - Decode three-bit decoder command
`define SSTF_A_STS_A 8'h0e
`define SSTF_A_STS_B 8'h0f
`define SSTF_A_LOA_H 8'h10
`define SSTF_A_LOA_L 8'h11
`define SSTF_A_LIM_H 8'h12
`define SSTF_A_LIM_L 8'h13
`define SSTF_A_FMT0 8'h14
`define SSTF_A_FMT1 8'h15
`define SSTF_RST_BYTE 8'h00
`define SSTF_F0_K1 7
`define SSTF_F0_K05 6
`define SSTF_F0_SYNC 5
`define SSTF_F0_HDR 4
`define SSTF_F0_SUB 3
`define SSTF_F0_USER 2
`define SSTF_F0_PAR 1
`define SSTF_F0_AUTO 0
`define SSTF_F1_BLKEN 7
`define SSTF_F1_BLKSL 6
`define SSTF_F1_BYTEN 5
`define SSTF_F1_BYTSL 4
`define SSTF_F1_SBCEN 3
`define SSTF_F1_ALL_SUBCHANNEL_SELECT 2
`define SSTF_F1_SBCSTS 1
`define SSTF_F1_ZPAD 0
`define SSTF_INFO_FORM 2
`define SSTF_INFO_MODE 1
`define SSTF_Q_BIT 6
`define SSTF_LIM_LOW 11'h7ff
`define SSTF_LEN_SYNC 12'd12
`define SSTF_LEN_HDR 12'd4
`define SSTF_LEN_SUB 12'd8
`define SSTF_LEN_USER1 12'd2048
`define SSTF_LEN_USER2 12'd2324
`define SSTF_LEN_PAR1 12'd288
`define SSTF_LEN_PAR21 12'd280
`define SSTF_LEN_PAR22 12'd4
`define SSTF_LEN_FLAGS 12'd294
`define SSTF_LEN_SUBALL 12'd96
`define SSTF_LEN_SUBQ 12'd12
`define SSTF_LEN_PAD 12'd5
`define SSTF_OFS_HDR 12'd12
`define SSTF_OFS_SUB 12'd16
`define SSTF_OFS_DATA2 12'd24
`define SSTF_OFS_PAR1 12'd2064
`define SSTF_OFS_PAR21 12'd2072
`define SSTF_OFS_PAR22 12'd2348
`define SSTF_OFS_FLAGS 12'd2352
`define SSTF_OFS_SUBC 12'd2646
`define SSTF_OFS_INFO 12'd2742
`define SSTF_MASK_1K 12'd1023
`define SSTF_MASK_512 12'd511
`endif

// ### rtl/sstf_pkg.sv
package sstf_pkg;
  typedef enum logic [2:0] {
    CMD_OFF = 3'b000, CMD_MON = 3'b001, CMD_WRONLY = 3'b010, CMD_RT = 3'b011,
    CMD_ASYNC = 3'b100, CMD_SUBC = 3'b101, CMD_UNUSED = 3'b110, CMD_AUDIO = 3'b111
  } sstf_cmd_t;
  typedef enum logic [3:0] {
    SG_SYNC = 4'h0, SG_HDR = 4'h1, SG_SUB = 4'h2, SG_USER = 4'h3, SG_PAR = 4'h4,
    SG_FLAGS = 4'h5, SG_BLK = 4'h6, SG_SUBC = 4'h7, SG_STAT = 4'h8, SG_PAD = 4'h9,
    SG_END = 4'ha
  } sstf_seg_t;
  typedef enum logic [2:0] {
    XS_IDLE = 3'b000, XS_INFO = 3'b001, XS_PLAN = 3'b010, XS_SEL = 3'b011,
    XS_FETCH = 3'b100, XS_CAPT = 3'b101, XS_SEND = 3'b110
  } sstf_xstate_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sstf_regbus_t;
  typedef struct packed {
    logic done;
    logic corrected;
    logic edcErr;
    logic eccErr;
    logic [23:0] curAddr;
    logic [31:0] edcParity;
    logic [3:0] edcParityFlag;
    logic mode;
    logic form;
  } sstf_result_t;
endpackage : sstf_pkg

// ### tb/sstf_buf_model.sv
`timescale 1ns/10ps
module sstf_buf_model (
  input wire logic core_clk, // Clock
  input wire logic bufRdEn, // Read strobe
  input wire logic [19:0] bufRdAddr, // Read address
  input wire logic [19:0] xferBase, // Sector base
  input wire logic [7:0] info, // Sector info word
  output logic [7:0] bufRdData // Data, next cycle
);
  always_ff @(posedge core_clk) begin
    if (bufRdEn) begin
      bufRdData <= (bufRdAddr == xferBase + 20'd2742) ? info : bufRdAddr[7:0] ^ bufRdAddr[11:4];
    end else begin
      // Stale byte inverted so a late capture shows up
      bufRdData <= ~bufRdData;
    end
  end
endmodule : sstf_buf_model

// ### tb/tb.sv
`timescale 1ns/10ps
`include "sstf_consts.svh"
module tb;
  import sstf_pkg::*;
  logic core_clk = 1'b0;
  logic rst;
  sstf_regbus_t bus;
  sstf_cmd_t decoderCommandField;
  sstf_result_t result;
  logic [7:0] regRdData, blockStatusByte, byteStatusValue, subchannelStatus, subByte, flagWrData, subWrData;
  logic [7:0] bufRdData, hostData, info, lastFlag, v, b;
  logic repeatCorrection, dataStrobe, erasurePointer, subStrobe, flagWrEn, subWrEn, sectorBufInhibit;
  logic limitReached, xferStart, bufRdEn, hostValid, hostReady, hostBlockEnd, hostSectorEnd, xferBusy;
  logic [23:0] targetAddr;
  logic [19:0] limitAddr, xferBase, bufRdAddr;
  logic [8:0] lastOrderArea;
  logic [31:0] r;
  int seed = 32'hf8405c05;
  int miscompares = 0;
  int numChecks = 0;
  int idx, blk, nFlag, em, ef, hexp;
  int q[$], sq[$], eq[$];

  sstf_sector_status dut (.core_clk, .rst, .bus, .regRdData, .decoderCommandField, .repeatCorrection, .result,
    .targetAddr, .blockStatusByte, .byteStatusValue, .subchannelStatus, .dataStrobe, .erasurePointer, .subStrobe,
    .subByte, .flagWrEn, .flagWrData, .subWrEn, .subWrData, .sectorBufInhibit, .limitAddr, .limitReached,
    .lastOrderArea, .xferStart, .xferBase, .bufRdEn, .bufRdAddr, .bufRdData, .hostData, .hostValid, .hostReady,
    .hostBlockEnd, .hostSectorEnd, .xferBusy);
  sstf_buf_model mem (.core_clk, .bufRdEn, .bufRdAddr, .xferBase, .info, .bufRdData);

  always #5 core_clk = ~core_clk;

  task automatic check_out(input logic [31:0] got, input logic [31:0] exp, input string what);
    numChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : check_out

  task automatic check_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk) bus.rd <= 1'b0;
    #1;
    numChecks++;
    if (regRdData !== e) begin
      miscompares++;
      $display("[ERR] %0t read %0h got %0h exp %0h", $time, a, regRdData, e);
    end
  endtask : check_reg

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk) bus.wr <= 1'b0;
  endtask : reg_wr

  task wrap_up;
    $display("checks %0d miscompares %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  function automatic int pat(input int a);
    return (a ^ (a >> 4)) & 255;
  endfunction : pat

  task automatic seg(input int bs, input int ofs, input int len);
    for (int i = 0; i < len; i++) q.push_back(pat(bs + ofs + i));
  endtask : seg

  task automatic xfer(input logic [7:0] f0, input logic [7:0] f1, input logic [7:0] inf);
    int m2, f2, n, bs;
    reg_wr(`SSTF_A_FMT0, f0);
    reg_wr(`SSTF_A_FMT1, f1);
    m2 = inf[1];
    f2 = inf[2] & inf[1];
    bs = ($random(seed) & 255) << 12;
    blk = f0[7] ? 1024 : f0[6] ? 512 : 0;
    idx = 0;
    if (blk != 0) seg(bs, m2 ? 24 : 16, 2048);
    else begin
      if (f0[5]) seg(bs, 0, 12);
      if (f0[4]) seg(bs, 12, 4);
      if (f0[3] && m2) seg(bs, 16, 8);
      if (f0[2]) seg(bs, m2 ? 24 : 16, f2 ? 2324 : 2048);
      if (f0[1]) seg(bs, !m2 ? 2064 : f2 ? 2348 : 2072, !m2 ? 288 : f2 ? 4 : 280);
      if (f1[5] && f0[2]) seg(bs, 2352, 294);
      if (f1[7]) q.push_back(blockStatusByte);
      if (f1[3]) seg(bs, 2646, f1[2] ? 96 : 12);
      if (f1[3] && f1[1]) q.push_back(subchannelStatus);
      if (f1[3] && f1[1] && f1[0] && !f1[2]) repeat (5) q.push_back(0);
    end
    @(posedge core_clk) begin
      info <= inf;
      xferBase <= bs[19:0];
      xferStart <= 1'b1;
    end
    for (n = 0; n < 40000; n++) begin
      // Short sectors end early, so watch for the end from the first edge
      @(posedge core_clk) xferStart <= (n == 30) && (q.size() > 100);
      #1;
      if (hostSectorEnd === 1'b1) break;
    end
    if (n == 40000) begin
      check_out(1, 0, "transfer timeout");
      wrap_up();
    end
    check_out(q.size(), 0, "bytes left");
    @(posedge core_clk);
    #1 check_out(xferBusy, 0, "busy after sector");
    $display("test transfer %h %h %h done", f0, f1, inf);
  endtask : xfer

  always @(posedge core_clk) hostReady <= ($random(seed) & 3) != 0;

  always @(posedge core_clk) begin
    if (hostValid === 1'b1 && hostReady === 1'b1) begin
      if (q.size() == 0) check_out(1, 0, "extra host byte");
      else begin
        hexp = q.pop_front();
        check_out({hostBlockEnd, hostData}, {blk != 0 && (idx + 1) % blk == 0, hexp[7:0]}, "host byte");
      end
      idx++;
    end
    if (flagWrEn === 1'b1) begin
      nFlag++;
      lastFlag = flagWrData;
    end
    if (subWrEn === 1'b1) sq.push_back(subWrData);
  end

  initial begin
    rst = 1'b1;
    bus = '0;
    decoderCommandField = CMD_OFF;
    result = '0;
    {repeatCorrection, dataStrobe, erasurePointer, subStrobe, xferStart, hostReady} = '0;
    targetAddr = $random(seed);
    blockStatusByte = 8'h5c;
    byteStatusValue = 8'ha3;
    subchannelStatus = 8'h3e;
    {subByte, info, limitAddr, xferBase} = '0;
    {em, ef, nFlag, blk, idx} = '0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    for (int a = 14; a <= 21; a++) check_reg(a[7:0], `SSTF_RST_BYTE);
    check_reg(8'h20, 8'h00);
    reg_wr(`SSTF_A_LOA_H, 8'h01);
    reg_wr(`SSTF_A_LOA_L, 8'h9a);
    reg_wr(`SSTF_A_LIM_H, 8'h01);
    reg_wr(`SSTF_A_LIM_L, 8'h23);
    reg_wr(`SSTF_A_STS_B, 8'hff);
    check_reg(`SSTF_A_LOA_H, 8'h01);
    check_reg(`SSTF_A_LOA_L, 8'h9a);
    check_reg(`SSTF_A_LIM_H, 8'h01);
    check_reg(`SSTF_A_LIM_L, 8'h23);
    check_reg(`SSTF_A_STS_B, 8'h00);
    check_out(lastOrderArea, 9'h19a, "last area");
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk) limitAddr <= {9'h123, 11'h7ff} - 20'(i * 1025);
      repeat (2) @(posedge core_clk);
      #1 check_out(limitReached, i == 0, "limit");
    end
    $display("test registers done");
    for (int k = 0; k < 24; k++) begin
      r = $random(seed);
      @(posedge core_clk) begin
        decoderCommandField <= sstf_cmd_t'(k[2:0]);
        repeatCorrection <= r[0];
        result <= '{done: 1'b1, corrected: r[1], edcErr: r[2], eccErr: r[3],
          curAddr: targetAddr ^ (24'(r[4]) << (r[12:8] % 24)), edcParity: r[5] ? 32'h0 : 32'h1 << r[17:13],
          edcParityFlag: r[6] ? 4'h0 : 4'h1 << r[19:18], mode: r[7], form: r[20]};
      end
      if (k[2:0] == 3 || r[0]) begin
        em = r[7];
        ef = r[7] & r[20];
      end
      @(posedge core_clk) result.done <= 1'b0;
      check_reg(`SSTF_A_STS_A, {4'h0, r[1], r[2], r[3], r[4]});
      check_reg(`SSTF_A_STS_B, {5'h0, r[5] & r[6], em[0], ef[0]});
    end
    $display("test status done");
    reg_wr(`SSTF_A_FMT0, 8'h04);
    erasurePointer <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      reg_wr(`SSTF_A_FMT1, c[0] ? 8'h70 : 8'h60);
      decoderCommandField <= sstf_cmd_t'(c[2:0]);
      nFlag = 0;
      repeat (8) begin
        @(posedge core_clk) dataStrobe <= 1'b1;
        @(posedge core_clk) dataStrobe <= 1'b0;
      end
      repeat (3) @(posedge core_clk);
      check_out(nFlag, c == 2 || c == 3 || c == 7, "flag writes");
      if (nFlag != 0) check_out(lastFlag, c[0] ? byteStatusValue : 8'hff, "flag value");
    end
    $display("test byte flags done");
    decoderCommandField <= CMD_AUDIO;
    for (int s = 0; s < 2; s++) begin
      reg_wr(`SSTF_A_FMT1, s ? 8'h0c : 8'h08);
      #1 check_out(sectorBufInhibit, 1, "inhibit");
      v = $random(seed);
      sq.delete();
      eq.delete();
      for (int i = 0; i < 8; i++) begin
        b = $random(seed);
        b[6] = v[7 - i];
        eq.push_back(b);
        @(posedge core_clk) begin
          subStrobe <= 1'b1;
          subByte <= b;
        end
        @(posedge core_clk) subStrobe <= 1'b0;
      end
      repeat (3) @(posedge core_clk);
      if (s == 0) eq = '{v};
      check_out(sq.size(), eq.size(), "subcode writes");
      foreach (eq[i]) check_out(sq[i], eq[i], "subcode byte");
    end
    reg_wr(`SSTF_A_FMT1, 8'h00);
    decoderCommandField <= CMD_OFF;
    $display("test subcode done");
    reg_wr(`SSTF_A_FMT0, 8'h3e);
    @(posedge core_clk) xferStart <= 1'b1;
    @(posedge core_clk) xferStart <= 1'b0;
    repeat (10) @(posedge core_clk);
    #1 check_out(xferBusy, 0, "manual mode start");
    xfer(8'h3f, 8'h00, 8'h00);
    xfer(8'h0f, 8'h00, 8'h02);
    xfer(8'h3f, 8'h00, 8'h06);
    xfer(8'h19, 8'h00, 8'h00);
    xfer(8'h81, 8'h00, 8'h00);
    xfer(8'h41, 8'h00, 8'h02);
    xfer(8'h05, 8'he0, 8'h00);
    xfer(8'h01, 8'h0b, 8'h00);
    xfer(8'h01, 8'h0e, 8'h00);
    wrap_up();
  end
endmodule : tb
